// ---- core/qawd_eval.sv ----
module qawd_eval
	import qawd_pkg::*;
#(
	parameter int STEP_CYCLES = STEP_CYC
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic [REPLY_W-1:0] expected_reply,
	output logic [CHAL_W-1:0] challenge_value,
	output logic [1:0] reply_tally,
	output qawd_flags_t guard_state,
	output logic [FAIL_W-1:0] failure_count,
	output logic run_start
);

	// ==========================================
	// Bus slave
	logic acc;
	logic wr_pend_r;
	logic rd_pend_r;
	logic [7:0] addr_r;
	logic [31:0] hrdata_r;
	logic [31:0] rd_val;
	logic wr_en;

	// Word transfers only; hsize is not checked
	assign acc = hsel && htrans[1] && hready;

	// Reads get one wait state so read data leaves a flip-flop
	assign hreadyout = !rd_pend_r;
	assign hresp = 1'b0;
	assign hrdata = hrdata_r;
	assign wr_en = wr_pend_r;

	// Address phase capture
	always_ff @(posedge clk) begin
		if (!rstn) begin
			wr_pend_r <= 1'b0;
			rd_pend_r <= 1'b0;
			addr_r <= 8'h00;
		end else begin
			wr_pend_r <= acc && hwrite;
			rd_pend_r <= acc && !hwrite;
			if (acc) begin
				addr_r <= haddr[7:0];
			end
		end
	end

	// ==========================================
	// Configuration registers
	logic mode_r;
	logic [WIN1_W-1:0] win1_len_r;
	logic [WIN2_W-1:0] win2_len_r;
	logic cfg_wr;

	// Any change of mode or window length begins a fresh run, unless single-answer mode parks it
	assign cfg_wr = wr_en && (addr_r == CTRL_OFS || addr_r == WIN1_OFS || addr_r == WIN2_OFS);

	always_ff @(posedge clk) begin
		if (!rstn) begin
			mode_r <= MODE_RST;
			win1_len_r <= WIN1_RST;
			win2_len_r <= WIN2_RST;
		end else if (wr_en) begin
			if (addr_r == CTRL_OFS) begin
				mode_r <= hwdata[MODE_BIT];
			end
			if (addr_r == WIN1_OFS) begin
				win1_len_r <= hwdata[WIN1_W-1:0];
			end
			if (addr_r == WIN2_OFS) begin
				win2_len_r <= hwdata[WIN2_W-1:0];
			end
		end
	end

	// ==========================================
	// Window timing
	qawd_phase_t phase_r;
	logic [15:0] step_cnt_r;
	logic [WIN1_W-1:0] win_cnt_r;
	logic tick;
	logic win1_end;
	logic expire;
	logic restart;

	// One step is 0.55 ms of clock cycles
	assign tick = step_cnt_r == 16'(STEP_CYCLES - 1);

	// Window ends after field plus one steps
	assign win1_end = phase_r == PH_WIN1 && tick && win_cnt_r == win1_len_r;
	assign expire = phase_r == PH_WIN2 && tick
		&& win_cnt_r == {{(WIN1_W-WIN2_W){1'b0}}, win2_len_r};

	// Step and window counters restart with every run
	always_ff @(posedge clk) begin
		if (!rstn) begin
			step_cnt_r <= 16'h0000;
			win_cnt_r <= 8'h00;
		end else if (restart || phase_r == PH_OFF) begin
			step_cnt_r <= 16'h0000;
			win_cnt_r <= 8'h00;
		end else if (tick) begin
			step_cnt_r <= 16'h0000;
			win_cnt_r <= win1_end ? 8'h00 : win_cnt_r + 8'h01;
		end else begin
			step_cnt_r <= step_cnt_r + 16'h0001;
		end
	end

	// Phase: single-answer mode parks the evaluation
	always_ff @(posedge clk) begin
		if (!rstn) begin
			phase_r <= PH_WIN1;
		end else begin
			case (phase_r)
				PH_OFF: begin
					if (!mode_r) begin
						phase_r <= PH_WIN1;
					end
				end
				PH_WIN1: begin
					if (mode_r) begin
						phase_r <= PH_OFF;
					end else if (restart) begin
						phase_r <= PH_WIN1;
					end else if (win1_end) begin
						phase_r <= PH_WIN2;
					end
				end
				PH_WIN2: begin
					if (mode_r) begin
						phase_r <= PH_OFF;
					end else if (restart) begin
						phase_r <= PH_WIN1;
					end
				end
				default: begin
					phase_r <= PH_WIN1;
				end
			endcase
		end
	end

	// ==========================================
	// Reply tracking
	logic reply_ev;
	logic reply_ok;
	logic in_w1;
	logic [2:0] w1_cnt_r;
	logic [2:0] w2_cnt_r;
	logic bad_r;
	logic [2:0] n_w1;
	logic [2:0] n_w2;
	logic n_bad;
	logic fourth;
	logic eval;
	logic good;

	// A reply write outside multi-answer mode is dropped
	assign reply_ev = wr_en && addr_r == REPLY_OFS && phase_r != PH_OFF;
	assign reply_ok = hwdata[REPLY_W-1:0] == expected_reply;
	assign in_w1 = phase_r == PH_WIN1;

	// Counts including the reply of this cycle
	assign n_w1 = w1_cnt_r + {2'b00, reply_ev && in_w1};
	assign n_w2 = w2_cnt_r + {2'b00, reply_ev && !in_w1};
	assign n_bad = bad_r || (reply_ev && !reply_ok);

	// Fourth reply ends the run at once and wins over a timeout
	assign fourth = reply_ev && (n_w1 + n_w2) == 3'd4;
	assign eval = fourth || expire;
	assign restart = eval || cfg_wr;
	assign good = n_w1 == 3'd3 && n_w2 == 3'd1 && !n_bad;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			w1_cnt_r <= 3'd0;
			w2_cnt_r <= 3'd0;
			bad_r <= 1'b0;
		end else if (restart || phase_r == PH_OFF) begin
			w1_cnt_r <= 3'd0;
			w2_cnt_r <= 3'd0;
			bad_r <= 1'b0;
		end else begin
			w1_cnt_r <= n_w1;
			w2_cnt_r <= n_w2;
			bad_r <= n_bad;
		end
	end

	// Tally counts down from three; it names the byte the host owes next
	always_ff @(posedge clk) begin
		if (!rstn) begin
			reply_tally <= TALLY_FIRST;
		end else if (restart || phase_r == PH_OFF) begin
			reply_tally <= TALLY_FIRST;
		end else if (reply_ev) begin
			reply_tally <= reply_tally - 2'h1;
		end
	end

	// ==========================================
	// Run outcome
	qawd_flags_t flags_nxt;

	// One formula covers every row: the window-1 count picks the order
	// and premature outcome, any bad byte the wrong flag
	always_comb begin
		flags_nxt.wrong = n_bad;
		flags_nxt.premature = n_w1 == 3'd4;
		flags_nxt.order = n_w1 < 3'd3;
		flags_nxt.expiry = !fourth;
	end

	// Flags change only on evaluation so software reads the last outcome
	always_ff @(posedge clk) begin
		if (!rstn) begin
			guard_state <= '0;
		end else if (eval) begin
			guard_state <= flags_nxt;
		end
	end

	// Failure counter saturates at both ends
	always_ff @(posedge clk) begin
		if (!rstn) begin
			failure_count <= FAIL_RST;
		end else if (eval) begin
			if (good) begin
				if (failure_count != 4'h0) begin
					failure_count <= failure_count - 4'h1;
				end
			end else if (failure_count != FAIL_MAX) begin
				failure_count <= failure_count + 4'h1;
			end
		end
	end

	// Only a good run moves the challenge; failures repeat it
	always_ff @(posedge clk) begin
		if (!rstn) begin
			challenge_value <= CHAL_RST;
		end else if (eval && good) begin
			challenge_value <= next_challenge(challenge_value);
		end
	end

	// Pulse marks the first cycle after each restart; the run out of reset gets none
	always_ff @(posedge clk) begin
		if (!rstn) begin
			run_start <= 1'b0;
		end else begin
			run_start <= restart;
		end
	end

	// ==========================================
	// Read path
	always_comb begin
		rd_val = 32'h0000_0000;
		case (addr_r)
			CTRL_OFS: rd_val[MODE_BIT] = mode_r;
			WIN1_OFS: rd_val[WIN1_W-1:0] = win1_len_r;
			WIN2_OFS: rd_val[WIN2_W-1:0] = win2_len_r;
			STATUS_OFS: begin
				rd_val[3:0] = guard_state;
				rd_val[ST_TALLY_LSB +: 2] = reply_tally;
				rd_val[ST_WIN2_BIT] = phase_r == PH_WIN2;
				rd_val[ST_RUN_BIT] = phase_r != PH_OFF;
			end
			CHAL_OFS: rd_val[CHAL_W-1:0] = challenge_value;
			FAIL_OFS: rd_val[FAIL_W-1:0] = failure_count;
			default: rd_val = 32'h0000_0000;
		endcase
	end

	// Read data loads in the wait cycle and holds afterwards
	always_ff @(posedge clk) begin
		if (!rstn) begin
			hrdata_r <= 32'h0000_0000;
		end else if (rd_pend_r) begin
			hrdata_r <= rd_val;
		end
	end

endmodule

// ---- common/qawd_pkg.sv ----
package qawd_pkg;

	// ==========================================
	// Register offsets (byte addresses)
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] WIN1_OFS = 8'h04;
	localparam logic [7:0] WIN2_OFS = 8'h08;
	localparam logic [7:0] REPLY_OFS = 8'h0c;
	localparam logic [7:0] STATUS_OFS = 8'h10;
	localparam logic [7:0] CHAL_OFS = 8'h14;
	localparam logic [7:0] FAIL_OFS = 8'h18;

	// ==========================================
	// Field positions and widths
	localparam int MODE_BIT = 0;
	localparam int WIN1_W = 8;
	localparam int WIN2_W = 5;
	localparam int CHAL_W = 4;
	localparam int FAIL_W = 4;
	localparam int REPLY_W = 8;
	localparam int ST_TALLY_LSB = 4;
	localparam int ST_WIN2_BIT = 6;
	localparam int ST_RUN_BIT = 7;

	// ==========================================
	// Reset values
	localparam logic MODE_RST = 1'b0;
	localparam logic [WIN1_W-1:0] WIN1_RST = 8'h0f;
	localparam logic [WIN2_W-1:0] WIN2_RST = 5'h03;
	localparam logic [CHAL_W-1:0] CHAL_RST = 4'h0;
	localparam logic [FAIL_W-1:0] FAIL_RST = 4'h0;
	localparam logic [FAIL_W-1:0] FAIL_MAX = 4'hf;
	localparam logic [1:0] TALLY_FIRST = 2'h3;

	// ==========================================
	// Timing: one window step
	localparam int CLK_PERIOD_NS = 20;
	localparam int STEP_NS = 550000;
	localparam int STEP_CYC = STEP_NS / CLK_PERIOD_NS;

	// ==========================================
	// Types
	typedef struct packed {
		logic wrong;
		logic premature;
		logic order;
		logic expiry;
	} qawd_flags_t;

	typedef enum logic [1:0] {
		PH_OFF,
		PH_WIN1,
		PH_WIN2
	} qawd_phase_t;

	// Next challenge; an all-zero value must never lock up the chain
	function automatic logic [CHAL_W-1:0] next_challenge(input logic [CHAL_W-1:0] q);
		if (q == 4'h0) begin
			return 4'h1;
		end
		return {q[2:0], q[3] ^ q[2]};
	endfunction

endpackage

// ---- bench/qawd_answer_model.sv ----
module qawd_answer_model
	import qawd_pkg::*;
(
	input wire logic [CHAL_W-1:0] challenge_value,
	input wire logic [1:0] reply_tally,
	output logic [REPLY_W-1:0] expected_reply
);
	timeunit 1ns;
	timeprecision 1ns;
	// ==========================================
	// Stand-in answer source
	// Byte differs per challenge and per tally step, so a misplaced tally shows up
	assign expected_reply = {challenge_value, 2'h0, reply_tally} ^ 8'h5a;
endmodule

// ---- bench/qawd_eval_assertions.sv ----
module qawd_eval_assertions
	import qawd_pkg::*;
#(
	parameter int STEP_CYCLES = STEP_CYC
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [CHAL_W-1:0] challenge_value,
	input wire logic [1:0] reply_tally,
	input wire qawd_flags_t guard_state,
	input wire logic [FAIL_W-1:0] failure_count,
	input wire logic run_start
);
	timeunit 1ns;
	timeprecision 1ns;
	// ==========================================
	// One clock domain, so one default clocking and reset
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);

	a_fail_keeps_chal: assert property (failure_count == $past(failure_count) + 4'h1
		|-> $stable(challenge_value)) else $error("challenge moved on a failing run");
	a_pass_clears: assert property (failure_count + 4'h1 == $past(failure_count)
		|-> guard_state == 4'h0 ##[0:1] challenge_value != $past(challenge_value, 2))
		else $error("good run left flags or challenge wrong");
	a_early_excl: assert property (guard_state.premature
		|-> !guard_state.order && !guard_state.expiry) else $error("premature with window flags");
	a_tally_reload: assert property (run_start |-> reply_tally == TALLY_FIRST)
		else $error("tally not reloaded at run start");
	a_tally_step: assert property ($changed(reply_tally) && reply_tally != TALLY_FIRST
		|-> reply_tally == $past(reply_tally) - 2'h1) else $error("tally stepped wrong");
	a_flags_hold: assert property ($changed(guard_state) |-> run_start)
		else $error("flags changed outside evaluation");
	a_count_at_run: assert property ($changed(failure_count) |-> run_start)
		else $error("failure count changed outside evaluation");
	a_wait_one: assert property (!hreadyout |=> hreadyout) else $error("read wait too long");
	a_resp_okay: assert property (hresp == 1'b0) else $error("response not okay");
endmodule

bind qawd_eval qawd_eval_assertions #(.STEP_CYCLES(STEP_CYCLES)) chk (.clk(clk), .rstn(rstn),
	.hreadyout(hreadyout), .hresp(hresp), .challenge_value(challenge_value),
	.reply_tally(reply_tally), .guard_state(guard_state), .failure_count(failure_count),
	.run_start(run_start));

// ---- bench/qa_watchdog_multi_answer_eval_test.sv ----
module qa_watchdog_multi_answer_eval_test
	import qawd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int STEP = 4;
	localparam int RUN = (16 + 4) * STEP; // Default window fields 0x0f and 0x03
	logic clk, rstn, hsel, hwrite, hreadyout, hresp, run_start;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans, reply_tally;
	logic [2:0] hsize;
	logic [7:0] expected_reply, ex;
	logic [3:0] challenge_value, failure_count;
	qawd_flags_t guard_state;
	int bad_count, comparisons, gap;

	// ==========================================
	// Design, answer source and clock
	qawd_eval #(.STEP_CYCLES(STEP)) uut (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .expected_reply(expected_reply),
		.challenge_value(challenge_value), .reply_tally(reply_tally), .guard_state(guard_state),
		.failure_count(failure_count), .run_start(run_start));
	qawd_answer_model model (.challenge_value(challenge_value), .reply_tally(reply_tally),
		.expected_reply(expected_reply));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// ==========================================
	// Checking and bus tasks
	task automatic end_of_test();
		$display("counts: comparisons=%0d mismatches=%0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// Sample at the falling edge so the rising edge never races the design
	task automatic wt();
		int i;
		for (i = 0; i < 50; i++) begin
			@(negedge clk);
			rd = hrdata;
			ex = expected_reply;
			if (hreadyout === 1'b1) break;
		end
		if (i == 50) begin
			bad_count++;
			end_of_test();
		end
		@(posedge clk);
	endtask
	// A reply write takes its byte from the answer source during the address phase
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
		input logic rep, input logic bad);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {24'h0, a};
		wt();
		htrans <= 2'h0;
		hwdata <= rep ? {24'h0, ex ^ {8{bad}}} : d;
		wt();
	endtask
	task automatic sync();
		for (gap = 0; gap < 400; gap++) begin
			@(negedge clk);
			if (run_start === 1'b1) break;
		end
		if (gap == 400) begin
			bad_count++;
			end_of_test();
		end
		@(posedge clk);
	endtask
	function automatic logic [3:0] nxt(input logic [3:0] q);
		return (q == 4'h0) ? 4'h1 : {q[2:0], q[3] ^ q[2]};
	endfunction
	// One run: n1 replies early in window 1, n2 replies inside window 2
	// Called on the first cycle of a run, so no idle run pads the failure count
	task automatic run_case(input int n1, input logic [3:0] b1, input int n2,
		input logic [3:0] b2, input logic [3:0] ef);
		logic [3:0] f0, q0;
		int k;
		f0 = failure_count;
		q0 = challenge_value;
		for (k = 0; k < n1; k++) bus(1'b1, REPLY_OFS, 32'h0, 1'b1, b1[k]);
		if (n1 < 4) repeat (66 - 2 * n1) @(posedge clk);
		for (k = 0; k < n2; k++) bus(1'b1, REPLY_OFS, 32'h0, 1'b1, b2[k]);
		sync();
		cmp(guard_state, ef);
		cmp(failure_count, ef == 4'h0 ? (f0 == 4'h0 ? f0 : f0 - 4'h1) : f0 + 4'h1);
		cmp(challenge_value, ef == 4'h0 ? nxt(q0) : q0);
		$display("run %0d+%0d done", n1, n2);
	endtask

	// ==========================================
	// Scenarios
	task automatic t_regs();
		bus(1'b0, WIN1_OFS, 32'h0, 1'b0, 1'b0);
		cmp(rd, 32'h0000000f);
		bus(1'b0, WIN2_OFS, 32'h0, 1'b0, 1'b0);
		cmp(rd, 32'h00000003);
		bus(1'b0, CTRL_OFS, 32'h0, 1'b0, 1'b0);
		cmp(rd, 32'h00000000);
		bus(1'b1, FAIL_OFS, 32'h00000005, 1'b0, 1'b0);
		bus(1'b0, FAIL_OFS, 32'h0, 1'b0, 1'b0);
		cmp(rd, 32'h00000000);
		bus(1'b0, 8'h40, 32'h0, 1'b0, 1'b0);
		cmp(rd, 32'h00000000);
		$display("registers done");
	endtask
	task automatic t_timeout();
		sync();
		run_case(0, 4'h0, 0, 4'h0, 4'h3);
		sync();
		cmp(gap + 1, RUN);
		$display("timeout done");
	endtask
	task automatic t_parked();
		bus(1'b1, CTRL_OFS, 32'h00000001, 1'b0, 1'b0);
		bus(1'b1, REPLY_OFS, 32'h0, 1'b1, 1'b0);
		cmp(reply_tally, 2'h3);
		// Parked longer than a whole run: no timeout may be judged meanwhile
		repeat (RUN + 20) @(posedge clk);
		bus(1'b0, STATUS_OFS, 32'h0, 1'b0, 1'b0);
		cmp(rd, 32'h00000030);
		// Eleven failing runs and two good ones so far
		bus(1'b0, FAIL_OFS, 32'h0, 1'b0, 1'b0);
		cmp(rd, 32'h00000009);
		bus(1'b1, CTRL_OFS, 32'h00000000, 1'b0, 1'b0);
		// Running again in window 1, tally reloaded, old flags kept
		bus(1'b0, STATUS_OFS, 32'h0, 1'b0, 1'b0);
		cmp(rd, 32'h000000b0);
		$display("parked done");
	endtask

	// ==========================================
	// Main sequence
	initial begin
		rstn <= 1'b0;
		hsel <= 1'b0;
		haddr <= 32'h0;
		htrans <= 2'h0;
		hwrite <= 1'b0;
		hsize <= 3'h2;
		hwdata <= 32'h0;
		bad_count = 0;
		comparisons = 0;
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		t_regs();
		t_timeout();
		run_case(1, 4'h0, 1, 4'h0, 4'h3);
		run_case(2, 4'h0, 1, 4'h1, 4'hb);
		run_case(0, 4'h0, 4, 4'h0, 4'h2);
		run_case(1, 4'h0, 3, 4'h2, 4'ha);
		run_case(1, 4'h1, 2, 4'h0, 4'hb);
		run_case(0, 4'h0, 3, 4'h0, 4'h3);
		run_case(4, 4'h0, 0, 4'h0, 4'h4);
		run_case(4, 4'h8, 0, 4'h0, 4'hc);
		run_case(3, 4'h0, 1, 4'h0, 4'h0);
		run_case(3, 4'h0, 1, 4'h0, 4'h0);
		t_parked();
		end_of_test();
	end
endmodule
